// ---- dv/glass_panel.sv ----
`timescale 1ns/1ps
module glass_panel (
    input  wire logic        pclk,
    input  wire logic        clear,
    input  wire logic [3:0]  common_select,
    input  wire logic [31:0] display_column_pin,
    output logic      [3:0]  seen,
    output logic      [31:0] lit [4]
);
    // Passive glass: keep the column pattern under each driven common
    always_ff @(posedge pclk) begin
        for (int k = 0; k < 4; k++) begin
            if (clear) seen[k] <= 1'b0;
            else if (common_select[k]) begin
                seen[k] <= 1'b1;
                lit[k]  <= display_column_pin;
            end
        end
    end
endmodule

// ---- dv/lcd_monitor.sv ----
`timescale 1ns/1ps
module lcd_monitor #(
    parameter int SEGMENT_COUNT = 32,
    parameter int ADDR_WIDTH    = 12
) (
    input wire logic                     pclk,
    input wire logic                     presetn,
    input wire logic                     psel,
    input wire logic                     penable,
    input wire logic                     pwrite,
    input wire logic [ADDR_WIDTH-1:0]    paddr,
    input wire logic [31:0]              pwdata,
    input wire logic [31:0]              prdata,
    input wire logic                     pready,
    input wire logic                     pslverr,
    input wire logic                     low_power_mode,
    input wire logic [SEGMENT_COUNT-1:0] display_column_pin,
    input wire logic [3:0]               common_select,
    input wire logic                     drive_ground,
    input wire logic                     power_switch_closed,
    input wire logic                     bias_divider_connect
);
    logic [3:0] ctl_reg;
    // Address decode mirrored from the bus
    wire [8:0] idx     = paddr[10:2];
    wire       hi_ok   = (paddr >> 11) == '0;
    wire       mem_hit = idx >= 9'h050 && idx < 9'h050 + SEGMENT_COUNT;
    wire       map_ok  = hi_ok && (mem_hit || idx == 9'h02C ||
                         idx == 9'h02D || (idx == 9'h070 && !pwrite) ||
                         idx == 9'h071 || idx == 9'h072);
    wire       wr_now  = psel && penable && pwrite && pready && hi_ok;
    wire [3:0] ctl_next = idx == 9'h02C ? pwdata[3:0] :
                          idx == 9'h071 ? ctl_reg | pwdata[3:0] :
                          idx == 9'h072 ? ctl_reg & ~pwdata[3:0] : ctl_reg;
    // Shadow of the write-only control bits, outputs depend on them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) ctl_reg <= 4'h0;
        else if (wr_now) ctl_reg <= ctl_next;
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_DECODE: assert property (psel && penable |-> pslverr == !map_ok)
        else $error("slave error does not match the address map");
    AST_WO_READ: assert property (psel && penable && !pwrite &&
        (idx == 9'h02C || idx == 9'h02D) |-> prdata == 32'h0)
        else $error("write-only register read back nonzero");
    AST_BLANK: assert property (!$past(ctl_reg[0]) |->
        display_column_pin == '0)
        else $error("segment lit while display is off");
    AST_SWITCH: assert property ((ctl_reg[1] && !low_power_mode) [*2]
        |=> power_switch_closed)
        else $error("power switch not closed");
    AST_SLEEP: assert property ((low_power_mode && !ctl_reg[2]) [*2]
        |=> drive_ground && !power_switch_closed)
        else $error("sleep did not ground or open switch");
    AST_GROUND: assert property (drive_ground ==
        $past(low_power_mode && !ctl_reg[2]))
        else $error("ground level out of step with mode");
    AST_GROUND_PINS: assert property (drive_ground [*3] |->
        common_select == 4'h0 && display_column_pin == '0)
        else $error("pins driven while grounded");
    AST_DIVIDER: assert property (bias_divider_connect ==
        $past(ctl_reg[3]))
        else $error("divider enable wrong");
    AST_ONEHOT: assert property ($onehot0(common_select))
        else $error("more than one common active");
    AST_STEP: assert property (common_select != 4'h0 &&
        $past(common_select) != 4'h0 && $changed(common_select) |->
        common_select == 4'h1 ||
        common_select == $past(common_select) << 1)
        else $error("commons stepped out of order");
    cover property (drive_ground);
    cover property (common_select == 4'h8);
    cover property (psel && penable && pslverr);
endmodule

bind segment_lcd_controller lcd_monitor #(
    .SEGMENT_COUNT(SEGMENT_COUNT),
    .ADDR_WIDTH(ADDR_WIDTH)
) mon (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .low_power_mode, .display_column_pin,
    .common_select, .drive_ground, .power_switch_closed,
    .bias_divider_connect);

// ---- dv/segment_lcd_controller_tb.sv ----
`timescale 1ns/1ps
module segment_lcd_controller_tb;
    logic        pclk, presetn, psel, penable, pwrite, err, clear;
    logic        subclock_pin, osc_tick, low_power_mode, osc_en;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata, display_column_pin;
    wire         pready, pslverr, drive_ground, power_switch_closed;
    wire         bias_divider_connect;
    wire  [3:0]  common_select, seen;
    wire  [31:0] lit [4];
    int          error_cnt, checks_done, n;
    int          sub_cnt = 0;
    int          exp_t[4] = '{256, 512, 1024, 8192};
    logic [3:0]  mem_a = 4'hA, mem_b = 4'h5;

    segment_lcd_controller uut (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .prdata, .pready, .pslverr, .subclock_pin,
        .osc_tick, .low_power_mode, .display_column_pin, .common_select,
        .drive_ground, .power_switch_closed, .bias_divider_connect);
    glass_panel panel (.pclk, .clear, .common_select, .display_column_pin,
        .seen, .lit);

    initial begin
        pclk = 0;
        forever #50 pclk = ~pclk;
    end
    // Subclock stand-in runs at half pclk, oscillator tick every 4
    always @(posedge pclk) begin
        sub_cnt <= sub_cnt + 1;
        subclock_pin <= sub_cnt[0];
        osc_tick <= osc_en && sub_cnt[1:0] == 2'h0;
    end

    task check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task end_sim;
        $display("checks %0d errors %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer; holds the request until pready is seen high
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && k++ < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 20) begin
            error_cnt++;
            $display("ERROR t=%0t bus hang", $time);
            end_sim;
        end
    endtask
    // Cycles until the active common changes; bounded
    task wait_change(output int cyc);
        logic [3:0] prev;
        prev = common_select;
        cyc = 0;
        do begin
            @(posedge pclk);
            cyc++;
        end while (common_select === prev && cyc < 9000);
        if (common_select === prev) begin
            error_cnt++;
            $display("ERROR t=%0t scan stalled", $time);
            end_sim;
        end
    endtask
    // Clear spans one scan tick so a stale common is never counted
    task renew(input int cyc);
        @(posedge pclk);
        clear <= 1'b1;
        repeat (300) @(posedge pclk);
        clear <= 1'b0;
        repeat (cyc) @(posedge pclk);
    endtask

    initial begin
        {psel, penable, pwrite, paddr, pwdata, clear} = '0;
        {low_power_mode, presetn} = '0;
        osc_en = 1'b1;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        // Register access, aliases and refusals
        apb(1, 12'h0B0, 32'hFFFF_FFF9);
        apb(0, 12'h0B0, 0);
        check(rd, 0);
        apb(1, 12'h1C4, 2);
        apb(0, 12'h1C0, 0);
        check(rd[3:0], 4'hB);
        apb(1, 12'h1C8, 8);
        apb(0, 12'h1C0, 0);
        check(rd[3:0], 4'h3);
        check(bias_divider_connect, 0);
        check(power_switch_closed, 1);
        apb(1, 12'h1C4, 8);
        apb(0, 12'h0B4, 0);
        check(rd, 0);
        foreach (exp_t[i]) begin
            apb(0, i == 0 ? 12'h0AC : i == 1 ? 12'h1CC :
                   i == 2 ? 12'h800 : 12'h1C0, 0);
            check(err, i < 3);
        end
        apb(1, 12'h1C0, 0);
        check(err, 1);
        apb(1, 12'h140, mem_a);
        apb(1, 12'h1BC, mem_b);
        apb(0, 12'h1BC, 0);
        check(rd, mem_b);
        check(err, 0);
        $display("test registers done");
        // Tick period of every reference clock in quarter duty
        for (int c = 0; c < 4; c++) begin
            apb(1, 12'h0B4, c << 2 | 3);
            wait_change(n);
            wait_change(n);
            check(n, exp_t[c]);
        end
        $display("test frame rates done");
        for (int d = 0; d < 4; d++) begin
            apb(1, 12'h0B4, d);
            renew(2400);
            check(seen, (1 << (d + 1)) - 1);
        end
        for (int k = 0; k < 4; k++) begin
            check({lit[k][31], lit[k][0]}, {mem_b[k], mem_a[k]});
        end
        apb(1, 12'h1C8, 1);
        renew(1200);
        for (int k = 0; k < 4; k++) check(lit[k], 0);
        check(bias_divider_connect, 1);
        apb(1, 12'h1C4, 1);
        $display("test display data done");
        // Watch mode with oscillator stopped
        low_power_mode <= 1'b1;
        osc_en <= 1'b0;
        repeat (4) @(posedge pclk);
        check({drive_ground, power_switch_closed}, 2'b10);
        check(common_select, 0);
        check(display_column_pin, 0);
        apb(1, 12'h1C4, 4);
        wait_change(n);
        wait_change(n);
        check(n, 256);
        check({drive_ground, power_switch_closed}, 2'b01);
        $display("test low power done");
        end_sim;
    end
endmodule

// ---- logic/lcd_scan_sequencer.sv ----
`timescale 1ns/1ps
`include "segment_lcd_defines.svh"

module lcd_scan_sequencer (
    input  wire logic                              pclk,
    input  wire logic                              presetn,
    input  wire logic                              subclock_edge,
    input  wire logic                              osc_tick,
    input  wire segment_lcd_pkg::clock_select_type clock_sel,
    input  wire segment_lcd_pkg::duty_type         duty,
    input  wire logic                              force_ground,
    output logic [1:0]                             phase_reg,
    output segment_lcd_pkg::scan_state_type        state_reg
);
    import segment_lcd_pkg::*;

    localparam int SUB_DIV0 = `SUBCLOCK_HZ / `REF_ZERO_FRAME_HZ;
    localparam int SUB_DIV1 = `SUBCLOCK_HZ / `REF_ONE_FRAME_HZ;
    localparam int OSC_DIV2 = `REF_TWO_OSC_DIV;
    localparam int OSC_DIV3 = `REF_TWO_OSC_DIV * `REF_THREE_FACTOR;

    logic [7:0]     sub_cnt_reg;
    logic [10:0]    osc_cnt_reg;
    logic [1:0]     phase_next;
    scan_state_type state_next;
    logic           ref_tick;
    logic           tick0;
    logic           tick1;
    logic           tick2;
    logic           tick3;

    // Last phase index equals the duty code
    function automatic logic [1:0] last_phase(input duty_type d);
        last_phase = 2'(d);
    endfunction

    // Reference clock enables from the two dividers
    assign tick0 = subclock_edge
        && (sub_cnt_reg[6:0] == 7'(SUB_DIV0 - 1)); // RULE13
    assign tick1 = subclock_edge
        && (sub_cnt_reg == 8'(SUB_DIV1 - 1)); // RULE13
    assign tick2 = osc_tick
        && (osc_cnt_reg[7:0] == 8'(OSC_DIV2 - 1)); // RULE15
    assign tick3 = osc_tick
        && (osc_cnt_reg == 11'(OSC_DIV3 - 1)); // RULE16
    assign ref_tick = (clock_sel == ref_zero)  ? tick0 :
                      (clock_sel == ref_one)   ? tick1 :
                      (clock_sel == ref_two)   ? tick2 : tick3; // RULE12

    // Step each active common once per reference tick
    assign phase_next =
        (phase_reg >= last_phase(duty)) ? 2'h0 : phase_reg + 2'h1; // RULE14

    // Grounding parks the scan; restart is at phase zero
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            scan_stopped:  if (force_ground) begin
                               state_next = scan_grounded;
                           end else if (ref_tick) begin
                               state_next = scan_running;
                           end
            scan_running:  if (force_ground) begin
                               state_next = scan_grounded;
                           end
            scan_grounded: if (!force_ground) begin
                               state_next = scan_stopped;
                           end
            default:       state_next = scan_stopped;
        endcase
    end

    // Subclock divider counts synchronized subclock edges, only on pclk edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_cnt_reg <= 8'h00;
            osc_cnt_reg <= 11'h000;
        end else begin
            if (subclock_edge) begin
                sub_cnt_reg <= sub_cnt_reg + 8'h01; // RULE17
            end
            if (osc_tick) begin
                osc_cnt_reg <= osc_cnt_reg + 11'h001;
            end
        end
    end

    // Phase and scan state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= scan_stopped;
            phase_reg <= 2'h0;
        end else begin
            state_reg <= state_next;
            if (state_next != scan_running) begin
                phase_reg <= 2'h0;
            end else if (ref_tick && state_reg == scan_running) begin
                // The tick that starts the scan shows phase zero first
                phase_reg <= phase_next; // RULE19
            end
        end
    end
endmodule

// ---- logic/segment_lcd_controller.sv ----
`timescale 1ns/1ps
`include "segment_lcd_defines.svh"

// Behaviour
// RULE1: Display memory sits at indices 050-06F, or 050-067 when reduced.
// RULE2: Memory bit0 is common one's pixel, bit3 is common four's.
// RULE3: Written memory data reaches the segment pins with no further action.
// RULE4: Display control is a 4-bit write-only register at index 02C.
// RULE5: Single bits of display control set or clear without touching others.
// RULE6: Display off blanks all segments; on shows memory contents.
// RULE7: Power switch bit closes the internal drive switch.
// RULE8: Low-power bit off: sleep grounds all pins, opens the switch.
// RULE9: Low-power bit on: scanning continues in watch and subactive modes.
// RULE10: Divider bit connects the bias resistor chain through an enable.
// RULE11: Duty and clock register is 4-bit write-only at index 02D.
// RULE12: Upper two bits choose reference clock zero to three.
// RULE13: Static duty frames: 256 Hz on clock zero, 128 Hz on one.
// RULE14: Frame rate is static rate divided by number of commons.
// RULE15: Clock two is prescaled oscillator over 256 phase ticks.
// RULE16: Clock three runs one eighth as fast as clock two.
// RULE17: Subclock reference keeps frames running while system clock stops; here the divider counts subclock edges only on pclk edges.
// RULE18: Lower two bits: static, half, third, quarter duty.
// RULE19: Each frame steps through active commons, showing matching bits.
module segment_lcd_controller #(
    parameter int SEGMENT_COUNT = 32,
    parameter int ADDR_WIDTH    = 12
) (
    input  wire logic                     pclk,
    input  wire logic                     presetn,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [ADDR_WIDTH-1:0]    paddr,
    input  wire logic [31:0]              pwdata,
    output logic [31:0]                   prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     subclock_pin,
    input  wire logic                     osc_tick,
    input  wire logic                     low_power_mode,
    output logic [SEGMENT_COUNT-1:0]      display_column_pin,
    output logic [3:0]                    common_select,
    output logic                          drive_ground,
    output logic                          power_switch_closed,
    output logic                          bias_divider_connect
);
    import segment_lcd_pkg::*;

    localparam int LAST_IDX = (SEGMENT_COUNT == 32)
        ? int'(`IDX_MEM_LAST_FULL) : int'(`IDX_MEM_LAST_REDUCED);

    // Only the two documented memory sizes are decoded
    if (SEGMENT_COUNT != 32 && SEGMENT_COUNT != 24) begin : gen_bad_count
        $error("SEGMENT_COUNT must be 32 or 24");
    end

    // Index bits 10..2 must exist; any bits above must read as zero
    if (ADDR_WIDTH < 11 || ADDR_WIDTH > 32) begin : gen_bad_addr
        $error("ADDR_WIDTH must be 11 to 32");
    end

    logic [3:0]               mem_reg [SEGMENT_COUNT];
    logic [3:0]               control_reg;
    logic [3:0]               control_next;
    logic [3:0]               duty_clock_reg;
    logic [3:0]               duty_clock_next;
    logic [31:0]              prdata_reg;
    logic [31:0]              prdata_next;
    logic [SEGMENT_COUNT-1:0] column_reg;
    logic [SEGMENT_COUNT-1:0] column_next;
    logic [3:0]               common_reg;
    logic [3:0]               common_next;
    logic                     ground_reg;
    logic                     switch_reg;
    logic                     divider_reg;
    logic                     sub_meta_reg;
    logic                     sub_sync_reg;
    logic                     sub_prev_reg;
    logic [1:0]               phase;
    scan_state_type           scan_state;

    wire [8:0]  reg_idx;
    wire        high_zero;
    wire        setup_phase;
    wire        access_phase;
    wire        write_strobe;
    wire        hit_control;
    wire        hit_duty;
    wire        hit_status;
    wire        hit_set;
    wire        hit_clear;
    wire        hit_mem;
    wire        mapped;
    wire [4:0]  mem_idx;
    wire        subclock_edge;
    wire        display_on;
    wire        low_power_show;
    wire        force_ground;
    wire        running;
    duty_type         duty;
    clock_select_type clock_sel;

    // APB decode; register index is the word address
    assign reg_idx      = paddr[10:2];
    assign high_zero    = (paddr >> 11) == '0;
    assign setup_phase  = psel && !penable;
    assign access_phase = psel && penable;
    assign write_strobe = access_phase && pwrite;
    assign hit_control  = high_zero
        && reg_idx == `IDX_DISPLAY_CONTROL; // RULE4
    assign hit_duty     = high_zero
        && reg_idx == `IDX_DUTY_CLOCK; // RULE11
    assign hit_status   = high_zero && reg_idx == `IDX_STATUS;
    assign hit_set      = high_zero && reg_idx == `IDX_CONTROL_SET;
    assign hit_clear    = high_zero && reg_idx == `IDX_CONTROL_CLEAR;
    assign hit_mem      = high_zero
        && reg_idx >= `IDX_MEM_FIRST
        && reg_idx <= 9'(LAST_IDX); // RULE1
    assign mem_idx      = 5'(reg_idx - `IDX_MEM_FIRST);
    assign mapped       = hit_control || hit_duty || hit_status
        || hit_set || hit_clear || hit_mem;

    // Zero-wait slave; writes to the status word are refused
    assign pready  = 1'b1;
    assign pslverr = access_phase
        && (!mapped || (pwrite && hit_status));
    assign prdata  = prdata_reg;

    // Control fields
    assign display_on     = control_reg[`CTL_DISPLAY_ON];
    assign low_power_show = control_reg[`CTL_LOW_POWER_SHOW];
    assign duty      = duty_type'(duty_clock_reg[`DUTY_LSB +: 2]); // RULE18
    assign clock_sel =
        clock_select_type'(duty_clock_reg[`CLOCK_LSB +: 2]); // RULE12

    // Sleep without low-power display grounds every pin
    assign force_ground = low_power_mode && !low_power_show; // RULE8
    assign running      = scan_state == scan_running;

    // Full write, set-alias or clear-alias on display control
    assign control_next =
        (write_strobe && hit_control) ? pwdata[3:0] :
        (write_strobe && hit_set) ? control_reg | pwdata[3:0] : // RULE5
        (write_strobe && hit_clear) ? control_reg & ~pwdata[3:0] : // RULE5
        control_reg;
    assign duty_clock_next =
        (write_strobe && hit_duty) ? pwdata[3:0] : duty_clock_reg;

    // Read data latched in setup; control words read as zero
    assign prdata_next =
        !setup_phase ? prdata_reg :
        (hit_mem ? {28'h0000000, mem_reg[mem_idx]} :
         hit_status ? {23'h000000, low_power_mode, scan_state,
                       phase, control_reg} :
         32'h00000000);

    // Subclock pin is asynchronous; edge taken after two flops
    assign subclock_edge = sub_sync_reg && !sub_prev_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_meta_reg <= 1'b0;
            sub_sync_reg <= 1'b0;
            sub_prev_reg <= 1'b0;
        end else begin
            sub_meta_reg <= subclock_pin;
            sub_sync_reg <= sub_meta_reg;
            sub_prev_reg <= sub_sync_reg;
        end
    end

    // Reference dividers, duty stepping and grounding state
    lcd_scan_sequencer sequencer (
        .pclk          (pclk),
        .presetn       (presetn),
        .subclock_edge (subclock_edge),
        .osc_tick      (osc_tick),
        .clock_sel     (clock_sel),
        .duty          (duty),
        .force_ground  (force_ground),
        .phase_reg     (phase),
        .state_reg     (scan_state)
    );

    // Segment pin picks the memory bit of the current phase
    genvar s;
    generate
        for (s = 0; s < SEGMENT_COUNT; s++) begin : column_gen
            // Grounding clears the pins on the same edge as drive_ground
            assign column_next[s] = running && !force_ground
                && display_on // RULE6
                && mem_reg[s][phase]; // RULE2
        end
    endgenerate

    // Commons stay low while grounded or before the first tick
    assign common_next = (running && !force_ground)
        ? 4'(4'h1 << phase) : 4'h0; // RULE19

    // Registers written by software
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            control_reg    <= `CONTROL_RESET;
            duty_clock_reg <= `DUTY_CLOCK_RESET;
            prdata_reg     <= 32'h00000000;
        end else begin
            control_reg    <= control_next;
            duty_clock_reg <= duty_clock_next;
            prdata_reg     <= prdata_next;
        end
    end

    // Display memory; CPU port writes, scan port reads above
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < SEGMENT_COUNT; i++) begin
                mem_reg[i] <= 4'h0;
            end
        end else if (write_strobe && hit_mem) begin
            mem_reg[mem_idx] <= pwdata[3:0]; // RULE3
        end
    end

    // Pin outputs, one cycle behind their causes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            column_reg  <= '0;
            common_reg  <= 4'h0;
            ground_reg  <= 1'b0;
            switch_reg  <= 1'b0;
            divider_reg <= 1'b0;
        end else begin
            column_reg  <= column_next; // RULE3
            common_reg  <= common_next; // RULE9
            ground_reg  <= force_ground; // RULE8
            switch_reg  <= control_reg[`CTL_POWER_SWITCH]
                && !force_ground; // RULE7
            divider_reg <= control_reg[`CTL_DIVIDER_ON]; // RULE10
        end
    end

    assign display_column_pin   = column_reg;
    assign common_select        = common_reg;
    assign drive_ground         = ground_reg;
    assign power_switch_closed  = switch_reg;
    assign bias_divider_connect = divider_reg;
endmodule

// ---- logic/segment_lcd_defines.svh ----
`ifndef SEGMENT_LCD_DEFINES_SVH
`define SEGMENT_LCD_DEFINES_SVH

// Register indices; byte address is four times the index
`define IDX_DISPLAY_CONTROL  9'h02C
`define IDX_DUTY_CLOCK       9'h02D
`define IDX_MEM_FIRST        9'h050
`define IDX_MEM_LAST_FULL    9'h06F
`define IDX_MEM_LAST_REDUCED 9'h067
`define IDX_STATUS           9'h070
`define IDX_CONTROL_SET      9'h071
`define IDX_CONTROL_CLEAR    9'h072

// Display control bit positions
`define CTL_DISPLAY_ON       0
`define CTL_POWER_SWITCH     1
`define CTL_LOW_POWER_SHOW   2
`define CTL_DIVIDER_ON       3

// Duty and clock select field positions
`define DUTY_LSB             0
`define CLOCK_LSB            2

// Reset values
`define CONTROL_RESET        4'h0
`define DUTY_CLOCK_RESET     4'h0

// Reference clock rates
`define SUBCLOCK_HZ          32768
`define REF_ZERO_FRAME_HZ    256
`define REF_ONE_FRAME_HZ     128
`define REF_TWO_OSC_DIV      256
`define REF_THREE_FACTOR     8

`endif

// ---- logic/segment_lcd_pkg.sv ----
package segment_lcd_pkg;

    typedef enum logic [1:0] {
        duty_static  = 2'h0,
        duty_half    = 2'h1,
        duty_third   = 2'h2,
        duty_quarter = 2'h3
    } duty_type;

    typedef enum logic [1:0] {
        ref_zero  = 2'h0,
        ref_one   = 2'h1,
        ref_two   = 2'h2,
        ref_three = 2'h3
    } clock_select_type;

    // Gray along stopped -> running -> grounded
    typedef enum logic [1:0] {
        scan_stopped  = 2'b00,
        scan_running  = 2'b01,
        scan_grounded = 2'b11
    } scan_state_type;

endpackage
